//--- rtl/fun_pkg.sv
// Constants, types and helper functions of the firmware upgrade node.
// Assumes a single 20 MHz clock and requests decoded by an upstream MAC.
//
// Notes on behaviour
// - Control requests count only when unicast; data never accepted by broadcast.
// - Replies are issued only to requests that arrived by unicast.
// - Image delivery never relies on link-level retransmission being present.
// - Whole image is integrity checked and held until an execute request.
// - Trial expiry or abort during trial drops the new image and reverts.
// - Confirm during trial makes the new image the only valid one.
// - Both images stay locked until confirmation, trial expiry or an abort.
// - Payload is image then signature, split using the signalled signature length.
// - Page length is 32, 64, 128 or 192 bytes, set by start request.
// - Page total is image length over page length rounded down, plus one.
// - Download active attribute at 0x0070 reads 1 while receiving, else 0.
// - Attribute at 0x0071 counts image data packets received so far.
// - Exactly one state at a time; any exception moves to exception.
// - Idle answers information requests, ignores data, replies state 0 otherwise.
// - Valid start request in idle enters receiving, a bad one exception; receiving replies state 1.
// - Full image received: checks pass go complete, any failure goes exception.
// - Abort in receiving or complete replies 0 and returns to idle.
// - Complete replies state 2 to state requests and stays complete.
// - Execute with delay enters countdown (state 3); zero delay enters upgrade.
// - Upgrade replies 4; confirm accepts, abort rejects, expiry rejects to exception.
// - Exception replies 5, ignores data; only abort returns to idle.
package fun_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [15:0] FUN_ADDR_DL_ACTIVE = 16'h0070;
  localparam logic [15:0] FUN_ADDR_RX_COUNT = 16'h0071;
  localparam logic [15:0] FUN_ADDR_CTRL = 16'h0072;
  localparam logic [15:0] FUN_ADDR_STATE = 16'h0073;
  localparam int FUN_CTRL_MCAST_BIT = 0;
  localparam logic FUN_CTRL_MCAST_RESET = 1'h0;

  localparam logic [11:0] FUN_MAX_PAGES = 12'h100;
  localparam int FUN_MAP_WORDS = 8;

  localparam logic [7:0] FUN_PAGE_LEN_32 = 8'h20;
  localparam logic [7:0] FUN_PAGE_LEN_64 = 8'h40;
  localparam logic [7:0] FUN_PAGE_LEN_128 = 8'h80;
  localparam logic [7:0] FUN_PAGE_LEN_192 = 8'hc0;

  localparam logic [2:0] FUN_CODE_IDLE = 3'h0;
  localparam logic [2:0] FUN_CODE_RECEIVING = 3'h1;
  localparam logic [2:0] FUN_CODE_COMPLETE = 3'h2;
  localparam logic [2:0] FUN_CODE_COUNTDOWN = 3'h3;
  localparam logic [2:0] FUN_CODE_UPGRADE = 3'h4;
  localparam logic [2:0] FUN_CODE_EXCEPTION = 3'h5;

  localparam int FUN_CLK_HZ = 32'h0131_2d00;
  localparam int FUN_TIMER_UNIT_S = 32'h0000_0001;
  localparam int FUN_TICK_CYCLES = FUN_TIMER_UNIT_S * FUN_CLK_HZ;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [3:0] {
    FUN_REQ_NONE = 4'h0,
    FUN_REQ_INFORMATION = 4'h1,
    FUN_REQ_STATE = 4'h2,
    FUN_REQ_MISSING_PAGE = 4'h3,
    FUN_REQ_UPGRADE_START = 4'h4,
    FUN_REQ_IMAGE_DATA = 4'h5,
    FUN_REQ_EXECUTE = 4'h6,
    FUN_REQ_CONFIRM = 4'h7,
    FUN_REQ_ABORT = 4'h8
  } fun_req_e;

  typedef enum logic [1:0] {
    FUN_CAST_UNICAST = 2'h0,
    FUN_CAST_MULTICAST = 2'h1,
    FUN_CAST_BROADCAST = 2'h2
  } fun_cast_e;

  typedef enum logic [1:0] {
    FUN_RSP_INFORMATION = 2'h0,
    FUN_RSP_STATE = 2'h1,
    FUN_RSP_MISSING_LIST = 2'h2,
    FUN_RSP_MISSING_BITMAP = 2'h3
  } fun_rsp_e;

  typedef enum logic [2:0] {
    FUN_ST_IDLE = 3'b000,
    FUN_ST_RECEIVING = 3'b001,
    FUN_ST_COMPLETE = 3'b011,
    FUN_ST_COUNTDOWN = 3'b010,
    FUN_ST_UPGRADE = 3'b110,
    FUN_ST_EXCEPTION = 3'b111
  } fun_state_e;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] fun_page_len(input logic [1:0] code);
    case (code)
      2'h0: fun_page_len = FUN_PAGE_LEN_32;
      2'h1: fun_page_len = FUN_PAGE_LEN_64;
      2'h2: fun_page_len = FUN_PAGE_LEN_128;
      default: fun_page_len = FUN_PAGE_LEN_192;
    endcase
  endfunction : fun_page_len

  function automatic logic [11:0] fun_page_total(input logic [15:0] len,
                                                 input logic [1:0] code);
    logic [15:0] quot;
    quot = len / {8'h00, fun_page_len(code)};
    fun_page_total = quot[11:0] + 12'h001;
  endfunction : fun_page_total

  function automatic logic [2:0] fun_state_code(input fun_state_e st);
    case (st)
      FUN_ST_IDLE: fun_state_code = FUN_CODE_IDLE;
      FUN_ST_RECEIVING: fun_state_code = FUN_CODE_RECEIVING;
      FUN_ST_COMPLETE: fun_state_code = FUN_CODE_COMPLETE;
      FUN_ST_COUNTDOWN: fun_state_code = FUN_CODE_COUNTDOWN;
      FUN_ST_UPGRADE: fun_state_code = FUN_CODE_UPGRADE;
      default: fun_state_code = FUN_CODE_EXCEPTION;
    endcase
  endfunction : fun_state_code

endpackage : fun_pkg

//--- rtl/fun_tmr_if.sv
// Interface between the upgrade controller and one of its second timers.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface fun_tmr_if;
  logic load;
  logic [15:0] secs;
  logic stop;
  logic done;
  modport ctrl (output load, output secs, output stop, input done);
  modport tmr (input load, input secs, input stop, output done);
endinterface : fun_tmr_if
`default_nettype wire

//--- rtl/fun_sec_timer.sv
// Down counter in whole seconds with a cycle prescaler.
// Assumes load and stop come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module fun_sec_timer #(
  parameter int unsigned TICK_CYCLES = fun_pkg::FUN_TICK_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  fun_tmr_if.tmr tmr_io
);
  import fun_pkg::*;

  logic running_ff;
  logic done_ff;
  logic [15:0] secs_left_ff;
  logic [31:0] tick_ff;

  assign tmr_io.done = done_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Done stays high until the next load or stop, so no expiry is missed.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      running_ff <= 1'b0;
      done_ff <= 1'b0;
      secs_left_ff <= 16'h0000;
      tick_ff <= 32'h0000_0000;
    end else if (tmr_io.stop) begin
      running_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (tmr_io.load) begin
      running_ff <= 1'b1;
      done_ff <= 1'b0;
      secs_left_ff <= tmr_io.secs;
      tick_ff <= 32'(TICK_CYCLES - 1);
    end else if (running_ff) begin
      if (secs_left_ff == 16'h0000) begin
        running_ff <= 1'b0;
        done_ff <= 1'b1;
      end else if (tick_ff == 32'h0000_0000) begin
        tick_ff <= 32'(TICK_CYCLES - 1);
        secs_left_ff <= secs_left_ff - 16'h0001;
      end else begin
        tick_ff <= tick_ff - 32'h0000_0001;
      end
    end
  end

endmodule : fun_sec_timer
`default_nettype wire

//--- rtl/fun_node_fsm.sv
// Service node firmware upgrade controller: request interpreter, page
// tracking, integrity hand-off, restart countdown and trial period.
// Assumes requests arrive already decoded, one per cycle, on this clock.
`timescale 1ns/1ps
`default_nettype none
module fun_node_fsm #(
  parameter int unsigned SEC_TICK_CYCLES = fun_pkg::FUN_TICK_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic req_valid_in,
  input wire fun_pkg::fun_req_e req_kind_in,
  input wire fun_pkg::fun_cast_e req_cast_in,
  input wire logic [1:0] req_page_length_in,
  input wire logic [15:0] req_image_length_in,
  input wire logic [15:0] req_sig_length_in,
  input wire logic [15:0] req_restart_delay_in,
  input wire logic [15:0] req_trial_period_in,
  input wire logic [7:0] req_page_in,
  input wire logic [7:0] req_data_len_in,
  input wire logic exception_in,
  input wire logic check_done_in,
  input wire logic crc_ok_in,
  input wire logic sig_ok_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  output logic reply_valid_out,
  output fun_pkg::fun_rsp_e reply_kind_out,
  output logic [2:0] reply_state_out,
  output logic [7:0] reply_base_out,
  output logic [31:0] reply_bitmap_out,
  output logic check_start_out,
  output logic reboot_out,
  output logic image_commit_out,
  output logic image_revert_out,
  output logic images_locked_out,
  output logic new_image_active_out,
  output logic store_valid_out,
  output logic [15:0] store_offset_out,
  output logic [7:0] store_len_out,
  output logic [7:0] store_image_bytes_out
);
  import fun_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  fun_state_e state_ff;
  fun_state_e nxt_state;
  logic ctrl_mcast_ff;
  logic [7:0] page_len_ff;
  logic [15:0] image_len_ff;
  logic [15:0] fw_len_ff;
  logic [8:0] page_total_ff;
  logic [8:0] seen_total_ff;
  logic [15:0] rx_count_ff;
  logic [15:0] trial_ff;
  logic chk_busy_ff;
  logic chk_done_ff;
  logic chk_pass_ff;
  logic locked_ff;
  logic [31:0] seen_map_ff [FUN_MAP_WORDS];

  logic ctl_ok;
  logic data_ok;
  logic rsp_fire;
  fun_rsp_e rsp_kind;
  logic [2:0] rsp_code;
  logic start_acc;
  logic exec_acc;
  logic start_bad;
  logic [11:0] start_total;
  logic cd_load;
  logic cd_stop;
  logic tr_load;
  logic tr_stop;
  logic reboot;
  logic commit;
  logic revert;
  logic chk_start;
  logic data_acc;
  logic pg_in_range;
  logic pg_last;
  logic pg_seen;
  logic [15:0] pg_off;
  logic [15:0] pg_remain;
  logic [7:0] exp_len;
  logic page_store;
  logic [15:0] img_diff;
  logic [7:0] img_bytes;
  logic [31:0] miss_map;
  logic [15:0] rd_value;

  fun_tmr_if cd_tmr_if ();
  fun_tmr_if tr_tmr_if ();

  fun_sec_timer #(.TICK_CYCLES(SEC_TICK_CYCLES)) u_countdown (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .tmr_io(cd_tmr_if)
  );

  fun_sec_timer #(.TICK_CYCLES(SEC_TICK_CYCLES)) u_trial (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .tmr_io(tr_tmr_if)
  );

  assign cd_tmr_if.load = cd_load;
  assign cd_tmr_if.secs = req_restart_delay_in;
  assign cd_tmr_if.stop = cd_stop;
  assign tr_tmr_if.load = tr_load;
  assign tr_tmr_if.secs = exec_acc ? req_trial_period_in : trial_ff;
  assign tr_tmr_if.stop = tr_stop;

  ////////////////////////////////////////////////////////////////////////////
  // Request qualification by delivery mode.
  assign ctl_ok = req_valid_in && (req_kind_in != FUN_REQ_NONE) &&
                  (req_kind_in != FUN_REQ_IMAGE_DATA) &&
                  (req_cast_in == FUN_CAST_UNICAST);
  assign data_ok = req_valid_in && (req_kind_in == FUN_REQ_IMAGE_DATA) &&
                   ((req_cast_in == FUN_CAST_UNICAST) ||
                    ((req_cast_in == FUN_CAST_MULTICAST) &&
                     ctrl_mcast_ff));

  assign start_total = fun_page_total(req_image_length_in,
                                      req_page_length_in);
  assign start_bad = (start_total > FUN_MAX_PAGES) ||
                     (req_sig_length_in > req_image_length_in);

  ////////////////////////////////////////////////////////////////////////////
  // Page checks for an incoming data packet.
  assign pg_in_range = {1'b0, req_page_in} < page_total_ff;
  assign pg_last = {1'b0, req_page_in} == (page_total_ff - 9'h001);
  assign pg_off = 16'({8'h00, req_page_in} * {8'h00, page_len_ff});
  assign pg_remain = image_len_ff - pg_off;
  assign exp_len = pg_last ? pg_remain[7:0] : page_len_ff;
  assign pg_seen = seen_map_ff[req_page_in[7:5]][req_page_in[4:0]];
  assign data_acc = data_ok && (state_ff == FUN_ST_RECEIVING) &&
                    !exception_in;
  assign page_store = data_acc && pg_in_range &&
                      (req_data_len_in == exp_len) && !pg_seen;
  assign img_diff = fw_len_ff - pg_off;

  always_comb begin
    img_bytes = 8'h00;
    if (pg_off < fw_len_ff) begin
      if (img_diff >= {8'h00, req_data_len_in}) begin
        img_bytes = req_data_len_in;
      end else begin
        img_bytes = img_diff[7:0];
      end
    end
  end

  always_comb begin
    miss_map = 32'h0000_0000;
    for (int i = 0; i < 32; i++) begin
      miss_map[i] = !seen_map_ff[req_page_in[7:5]][i] &&
                    ({1'b0, req_page_in[7:5], 5'(i)} < page_total_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Upgrade state machine.
  always_comb begin
    nxt_state = state_ff;
    rsp_fire = 1'b0;
    rsp_kind = FUN_RSP_STATE;
    rsp_code = fun_state_code(state_ff);
    start_acc = 1'b0;
    exec_acc = 1'b0;
    cd_load = 1'b0;
    cd_stop = 1'b0;
    tr_load = 1'b0;
    tr_stop = 1'b0;
    reboot = 1'b0;
    commit = 1'b0;
    revert = 1'b0;
    chk_start = 1'b0;
    if (exception_in && (state_ff != FUN_ST_EXCEPTION)) begin
      nxt_state = FUN_ST_EXCEPTION;
      cd_stop = 1'b1;
      tr_stop = 1'b1;
    end else if (ctl_ok) begin
      rsp_fire = 1'b1;
      case (req_kind_in)
        FUN_REQ_INFORMATION: begin
          rsp_kind = FUN_RSP_INFORMATION;
        end
        FUN_REQ_ABORT: begin
          rsp_code = FUN_CODE_IDLE;
          nxt_state = FUN_ST_IDLE;
          cd_stop = 1'b1;
          tr_stop = 1'b1;
          revert = locked_ff;
        end
        FUN_REQ_UPGRADE_START: begin
          if (state_ff == FUN_ST_IDLE) begin
            if (start_bad) begin
              nxt_state = FUN_ST_EXCEPTION;
              rsp_code = FUN_CODE_EXCEPTION;
            end else begin
              start_acc = 1'b1;
              nxt_state = FUN_ST_RECEIVING;
              rsp_code = FUN_CODE_RECEIVING;
            end
          end
        end
        FUN_REQ_MISSING_PAGE: begin
          if (state_ff == FUN_ST_RECEIVING) begin
            rsp_kind = FUN_RSP_MISSING_BITMAP;
          end
        end
        FUN_REQ_EXECUTE: begin
          if ((state_ff == FUN_ST_COMPLETE) ||
              (state_ff == FUN_ST_COUNTDOWN)) begin
            exec_acc = 1'b1;
            if (req_restart_delay_in != 16'h0000) begin
              nxt_state = FUN_ST_COUNTDOWN;
              rsp_code = FUN_CODE_COUNTDOWN;
              cd_load = 1'b1;
            end else begin
              nxt_state = FUN_ST_UPGRADE;
              rsp_code = FUN_CODE_UPGRADE;
              cd_stop = 1'b1;
              tr_load = 1'b1;
              reboot = 1'b1;
            end
          end
        end
        FUN_REQ_CONFIRM: begin
          if (state_ff == FUN_ST_UPGRADE) begin
            nxt_state = FUN_ST_IDLE;
            rsp_code = FUN_CODE_IDLE;
            tr_stop = 1'b1;
            commit = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end else if ((state_ff == FUN_ST_RECEIVING) && chk_done_ff) begin
      nxt_state = chk_pass_ff ? FUN_ST_COMPLETE : FUN_ST_EXCEPTION;
    end else if ((state_ff == FUN_ST_RECEIVING) && !chk_busy_ff &&
                 (seen_total_ff == page_total_ff)) begin
      chk_start = 1'b1;
    end else if ((state_ff == FUN_ST_COUNTDOWN) && cd_tmr_if.done) begin
      nxt_state = FUN_ST_UPGRADE;
      cd_stop = 1'b1;
      tr_load = 1'b1;
      reboot = 1'b1;
    end else if ((state_ff == FUN_ST_UPGRADE) && tr_tmr_if.done) begin
      nxt_state = FUN_ST_EXCEPTION;
      tr_stop = 1'b1;
      revert = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state_ff <= FUN_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Download parameters latched by an accepted start request; trial period by an accepted execute.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      page_len_ff <= FUN_PAGE_LEN_32;
      image_len_ff <= 16'h0000;
      fw_len_ff <= 16'h0000;
      page_total_ff <= 9'h001;
    end else if (start_acc) begin
      page_len_ff <= fun_page_len(req_page_length_in);
      image_len_ff <= req_image_length_in;
      fw_len_ff <= req_image_length_in - req_sig_length_in;
      page_total_ff <= start_total[8:0];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      trial_ff <= 16'h0000;
    end else if (exec_acc) begin
      trial_ff <= req_trial_period_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Received page bitmap, one word per 32 pages.
  generate
    for (genvar w = 0; w < FUN_MAP_WORDS; w++) begin : g_map
      always_ff @(posedge core_clk_in) begin
        if (sys_rst_in || start_acc) begin
          seen_map_ff[w] <= 32'h0000_0000;
        end else if (page_store && (req_page_in[7:5] == 3'(w))) begin
          seen_map_ff[w][req_page_in[4:0]] <= 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || start_acc) begin
      seen_total_ff <= 9'h000;
    end else if (page_store) begin
      seen_total_ff <= seen_total_ff + 9'h001;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || start_acc) begin
      rx_count_ff <= 16'h0000;
    end else if (data_acc && (rx_count_ff != 16'hffff)) begin
      rx_count_ff <= rx_count_ff + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Integrity check hand-off; a result is held until the state consumes it.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || (nxt_state != FUN_ST_RECEIVING) || start_acc) begin
      chk_busy_ff <= 1'b0;
      chk_done_ff <= 1'b0;
      chk_pass_ff <= 1'b0;
    end else begin
      if (chk_start) begin
        chk_busy_ff <= 1'b1;
      end
      if (check_done_in && chk_busy_ff && !chk_done_ff) begin
        chk_done_ff <= 1'b1;
        chk_pass_ff <= crc_ok_in && sig_ok_in;
      end
    end
  end

  // Both images stay stored from a good download until commit or revert.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      locked_ff <= 1'b0;
    end else if (commit || revert) begin
      locked_ff <= 1'b0;
    end else if ((state_ff == FUN_ST_RECEIVING) &&
                 (nxt_state == FUN_ST_COMPLETE)) begin
      locked_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered replies, strobes and page store requests.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      reply_valid_out <= 1'b0;
      reply_kind_out <= FUN_RSP_STATE;
      reply_state_out <= FUN_CODE_IDLE;
      reply_base_out <= 8'h00;
      reply_bitmap_out <= 32'h0000_0000;
    end else begin
      reply_valid_out <= rsp_fire;
      if (rsp_fire) begin
        reply_kind_out <= rsp_kind;
        reply_state_out <= rsp_code;
        reply_base_out <= {req_page_in[7:5], 5'h00};
        reply_bitmap_out <= miss_map;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      check_start_out <= 1'b0;
      reboot_out <= 1'b0;
      image_commit_out <= 1'b0;
      image_revert_out <= 1'b0;
    end else begin
      check_start_out <= chk_start;
      reboot_out <= reboot;
      image_commit_out <= commit;
      image_revert_out <= revert;
    end
  end

  assign images_locked_out = locked_ff;
  assign new_image_active_out = (state_ff == FUN_ST_UPGRADE);

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      store_valid_out <= 1'b0;
      store_offset_out <= 16'h0000;
      store_len_out <= 8'h00;
      store_image_bytes_out <= 8'h00;
    end else begin
      store_valid_out <= page_store;
      if (page_store) begin
        store_offset_out <= pg_off;
        store_len_out <= req_data_len_in;
        store_image_bytes_out <= img_bytes;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      ctrl_mcast_ff <= FUN_CTRL_MCAST_RESET;
    end else if (reg_wr_in && (reg_addr_in == FUN_ADDR_CTRL)) begin
      ctrl_mcast_ff <= reg_wdata_in[FUN_CTRL_MCAST_BIT];
    end
  end

  always_comb begin
    rd_value = 16'h0000;
    case (reg_addr_in)
      FUN_ADDR_DL_ACTIVE: begin
        rd_value = {15'h0000, (state_ff == FUN_ST_RECEIVING)};
      end
      FUN_ADDR_RX_COUNT: rd_value = rx_count_ff;
      FUN_ADDR_CTRL: rd_value = {15'h0000, ctrl_mcast_ff};
      FUN_ADDR_STATE: rd_value = {13'h0000, fun_state_code(state_ff)};
      default: rd_value = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rd_value;
    end else begin
      reg_rdata_out <= 16'h0000;
    end
  end

endmodule : fun_node_fsm
`default_nettype wire

//--- testbench/fun_node_fsm_props.sv
// Checker of the upgrade node's request, reply and register ports.
// Assumes it is bound to every fun_node_fsm instance.
`timescale 1ns/1ps
`default_nettype none
module fun_node_fsm_props
  import fun_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic req_valid_in,
  input wire fun_req_e req_kind_in,
  input wire fun_cast_e req_cast_in,
  input wire logic exception_in,
  input wire logic reg_rd_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic reply_valid_out,
  input wire logic [2:0] reply_state_out,
  input wire logic image_commit_out,
  input wire logic new_image_active_out
);
  wire uc = req_valid_in && !exception_in && req_cast_in == FUN_CAST_UNICAST;
  wire up = uc && new_image_active_out;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  quiet_non_unicast_a: assert property (req_valid_in && !uc |=> !reply_valid_out)
    else $error("reply to a refused request");
  reply_has_cause_a: assert property (reply_valid_out |-> $past(uc))
    else $error("reply without a request");
  ctrl_gets_reply_a: assert property (uc && req_kind_in != FUN_REQ_NONE
    && req_kind_in != FUN_REQ_IMAGE_DATA |=> reply_valid_out)
    else $error("control request unanswered");
  data_silent_a: assert property (uc && req_kind_in == FUN_REQ_IMAGE_DATA
    |=> !reply_valid_out)
    else $error("reply to a data packet");
  abort_zero_a: assert property (uc && req_kind_in == FUN_REQ_ABORT
    |=> reply_valid_out && reply_state_out == 3'h0)
    else $error("abort reply not zero");
  upgrade_code_a: assert property (up && req_kind_in == FUN_REQ_STATE
    |=> reply_state_out == 3'h4)
    else $error("upgrade reply not four");
  confirm_idle_a: assert property (up && req_kind_in == FUN_REQ_CONFIRM
    |=> !new_image_active_out && reply_state_out == 3'h0
    && image_commit_out)
    else $error("confirm did not return idle");
  read_stands_a: assert property (reg_rd_in ##1 !reg_rd_in
    |=> reg_rdata_out == 16'h0)
    else $error("read data held too long");
endmodule : fun_node_fsm_props
bind fun_node_fsm fun_node_fsm_props fun_node_fsm_props_i (.*);
`default_nettype wire

//--- testbench/fun_chk_model.sv
// Integrity checker model: answers each start pulse a few cycles later.
// Assumes start_in is a one-cycle pulse on core_clk_in.
`timescale 1ns/1ps
`default_nettype none
module fun_chk_model (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic start_in,
  input wire logic good_in,
  output logic done_out,
  output logic ok_out
);
  logic [2:0] cnt_ff;
  always_ff @(posedge core_clk_in) begin
    cnt_ff <= sys_rst_in ? 3'h0 : start_in ? 3'h3 : cnt_ff - {2'h0, |cnt_ff};
    done_out <= !sys_rst_in && cnt_ff == 3'h1;
  end
  // The verdict is only meaningful with done; it is inverted elsewhere.
  assign ok_out = done_out ? good_in : !good_in;
endmodule : fun_chk_model
`default_nettype wire

//--- testbench/fun_node_fsm_tb_top.sv
// Bench of the upgrade node: request, register and integrity traffic.
// Assumes fun_pkg, the design, the checker and its model are compiled.
`timescale 1ns/1ps
`default_nettype none
module fun_node_fsm_tb_top;
  import fun_pkg::*;
  logic core_clk_in = 1'b0, sys_rst_in = 1'b1, req_valid_in = 1'b0;
  fun_req_e req_kind_in = FUN_REQ_NONE;
  fun_cast_e req_cast_in = FUN_CAST_UNICAST;
  logic [1:0] req_page_length_in = 2'h0;
  logic [15:0] req_image_length_in = 16'h28, req_sig_length_in = 16'h8;
  logic [15:0] req_restart_delay_in = 16'h1, req_trial_period_in = 16'hff;
  logic [7:0] req_page_in = 8'h0, req_data_len_in = 8'h20;
  logic exception_in = 1'b0, image_good = 1'b1, check_done_in;
  logic crc_ok_in, sig_ok_in, reply_valid_out, check_start_out;
  logic [15:0] reg_addr_in = 16'h0, reg_wdata_in = 16'h0, reg_rdata_out;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  fun_rsp_e reply_kind_out;
  logic [2:0] reply_state_out;
  logic [7:0] reply_base_out, store_len_out, store_image_bytes_out;
  logic [31:0] reply_bitmap_out;
  logic [15:0] store_offset_out;
  logic reboot_out, image_commit_out, image_revert_out, images_locked_out;
  logic new_image_active_out, store_valid_out;
  int bad_count = 0, n_tests = 0, cyc = 0;
  fun_node_fsm #(.SEC_TICK_CYCLES(4)) fun_node_fsm_i (.*);
  fun_chk_model fun_chk_model_i (.core_clk_in, .sys_rst_in,
    .start_in(check_start_out), .good_in(1'b1),
    .done_out(check_done_in), .ok_out(crc_ok_in));
  assign sig_ok_in = image_good;
  always #25 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic ck(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask : ck
  // Expected code: bit 3 is the reply pulse, bits 2:0 the state code.
  task automatic rq(input fun_req_e k, input fun_cast_e c, input logic [3:0] e);
    req_kind_in <= k;
    req_cast_in <= c;
    req_valid_in <= 1'b1;
    @(posedge core_clk_in);
    req_valid_in <= 1'b0;
    #1;
    ck({12'h0, reply_valid_out, e[3] ? reply_state_out : 3'h0}, {12'h0, e});
    @(posedge core_clk_in);
  endtask : rq
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    ck(reg_rdata_out, e);
    @(posedge core_clk_in);
  endtask : rd
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  task automatic img(input fun_cast_e c);
    req_page_in <= 8'h0;
    req_data_len_in <= 8'h20;
    rq(FUN_REQ_IMAGE_DATA, c, 4'h0);
    rd(16'h0071, 16'h1);
    ck({store_len_out, store_image_bytes_out}, 16'h2020);
    rq(FUN_REQ_MISSING_PAGE, FUN_CAST_UNICAST, 4'h9);
    ck({14'h0, reply_kind_out}, {14'h0, FUN_RSP_MISSING_BITMAP});
    ck(reply_bitmap_out[15:0], 16'h2);
    req_page_in <= 8'h1;
    req_data_len_in <= 8'h08;
    rq(FUN_REQ_IMAGE_DATA, FUN_CAST_UNICAST, 4'h0);
    repeat (12) @(posedge core_clk_in);
  endtask : img
  initial begin
    repeat (16) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge core_clk_in);
    rq(FUN_REQ_STATE, FUN_CAST_UNICAST, 4'h8);
    rq(FUN_REQ_CONFIRM, FUN_CAST_MULTICAST, 4'h0);
    rd(16'h0070, 16'h0);
    rd(16'h0090, 16'h0);
    rq(FUN_REQ_UPGRADE_START, FUN_CAST_UNICAST, 4'h9);
    rd(16'h0070, 16'h1);
    rq(FUN_REQ_EXECUTE, FUN_CAST_UNICAST, 4'h9);
    wr(16'h0071, 16'h5);
    rq(FUN_REQ_IMAGE_DATA, FUN_CAST_BROADCAST, 4'h0);
    wr(16'h0072, 16'h1);
    img(FUN_CAST_MULTICAST);
    rq(FUN_REQ_STATE, FUN_CAST_UNICAST, 4'ha);
    rq(FUN_REQ_EXECUTE, FUN_CAST_UNICAST, 4'hb);
    repeat (8) @(posedge core_clk_in);
    rq(FUN_REQ_STATE, FUN_CAST_UNICAST, 4'hc);
    rq(FUN_REQ_CONFIRM, FUN_CAST_UNICAST, 4'h8);
    image_good <= 1'b0;
    rq(FUN_REQ_UPGRADE_START, FUN_CAST_UNICAST, 4'h9);
    img(FUN_CAST_UNICAST);
    rq(FUN_REQ_EXECUTE, FUN_CAST_UNICAST, 4'hd);
    rq(FUN_REQ_ABORT, FUN_CAST_UNICAST, 4'h8);
    rq(FUN_REQ_UPGRADE_START, FUN_CAST_UNICAST, 4'h9);
    rq(FUN_REQ_ABORT, FUN_CAST_UNICAST, 4'h8);
    exception_in <= 1'b1;
    @(posedge core_clk_in);
    exception_in <= 1'b0;
    rq(FUN_REQ_STATE, FUN_CAST_UNICAST, 4'hd);
    wrap_up();
  end
endmodule : fun_node_fsm_tb_top
`default_nettype wire
